// ---- tfp_pin_model.sv ----
`timescale 1ns/1ps
module tfp_pin_model (
	input  wire logic clk,
	output logic      capture_pin,
	output logic      count_pin
);
	initial begin
		capture_pin = 1'h0;
		count_pin = 1'h0;
	end
	task automatic set_capture(input logic level);
		@(posedge clk);
		capture_pin <= level;
		repeat (2) @(posedge clk);
	endtask : set_capture
	// Count clock with half periods of several system clocks, idle low afterwards
	task automatic run_clock(input int periods, input int half);
		repeat (periods) begin
			count_pin <= 1'h1;
			repeat (half) @(posedge clk);
			count_pin <= 1'h0;
			repeat (half) @(posedge clk);
		end
		repeat (2) @(posedge clk);
	endtask : run_clock
endmodule : tfp_pin_model

// ---- tfp_pkg.sv ----
package tfp_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_MASK     = 8'h39;
	localparam logic [7:0] ADDR_FLAGS    = 8'h38;
	localparam logic [7:0] ADDR_GTC      = 8'h23;
	localparam logic [7:0] ADDR_CMPA_LO  = 8'h2A;
	localparam logic [7:0] ADDR_CMPA_HI  = 8'h2B;
	localparam logic [7:0] ADDR_CMPB_LO  = 8'h28;
	localparam logic [7:0] ADDR_CMPB_HI  = 8'h29;
	localparam logic [7:0] ADDR_CAPT_LO  = 8'h26;
	localparam logic [7:0] ADDR_CAPT_HI  = 8'h27;
	// ---------------------------------------------------------------
	// Field positions (mask and flag registers share them)
	// ---------------------------------------------------------------
	localparam int BIT_OVF  = 7;
	localparam int BIT_CMPA = 6;
	localparam int BIT_CMPB = 5;
	localparam int BIT_CAPT = 3;
	localparam int BIT_PRESCALER_RESET = 0;
	localparam logic [7:0] T1_FLAG_BITS = 8'hE8;
	localparam logic [7:0] MASK_RESET   = 8'h00;
	localparam logic [15:0] WIDE_RESET  = 16'h0000;
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	// ---------------------------------------------------------------
	// Clock select codes
	// ---------------------------------------------------------------
	localparam logic [2:0] CS_STOP  = 3'h0;
	localparam logic [2:0] CS_DIV1  = 3'h1;
	localparam logic [2:0] CS_DIV8  = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256  = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	// ---------------------------------------------------------------
	// Prescaler taps: counter low bits all ones
	// ---------------------------------------------------------------
	localparam int PRESCALER_WIDTH = 10;
	localparam int TAP8_BITS    = 3;
	localparam int TAP64_BITS   = 6;
	localparam int TAP256_BITS  = 8;
	localparam logic [PRESCALER_WIDTH-1:0] PRESCALER_ZERO = 10'h000;
	localparam logic [PRESCALER_WIDTH-1:0] PRESCALER_ONE  = 10'h001;
	// ---------------------------------------------------------------
	// Waveform modes of interest
	// ---------------------------------------------------------------
	localparam logic [3:0] WM_NORMAL     = 4'h0;
	localparam logic [3:0] WM_MATCH_A    = 4'h4;
	localparam logic [3:0] WM_MATCH_CAPT = 4'hC;
	localparam logic [3:0] WM_PFC_CAPT   = 4'h8;
	localparam logic [3:0] WM_PC_CAPT    = 4'hA;
	localparam logic [3:0] WM_FAST_CAPT  = 4'hE;
	localparam logic [3:0] WM_FAST_8BIT  = 4'h5;
	localparam logic [3:0] WM_FAST_9BIT  = 4'h6;
	localparam logic [3:0] WM_FAST_10BIT = 4'h7;
	localparam logic [3:0] WM_FAST_CMPA  = 4'hF;
endpackage : tfp_pkg

// ---- tfp_timer1_flags.sv ----
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Each 16-bit compare value is compared with the counter all the time.
// - 16-bit accesses go through one shared high-byte latch.
// - A capture event copies the counter into the capture value.
// - Interrupt request needs mask bit, global enable and flag all set.
// - Overflow flag sets at overflow or at the mode's defined point.
// - Flags clear on vector taken or on writing one; zero does nothing.
// - Match flags set in the timer cycle after counter equals compare.
// - Forced-compare strobes never set the match flags.
// - Capture flag sets on capture, or at top when capture is top.
// - One shared prescaler; each timer picks its own tap.
// - Select one counts every clock; selects two to five use taps 8,64,256,1024.
// - Prescaler runs freely whatever the clock selection.
// - Prescaler reset restarts the period for both timers.
// - Count pin goes through a half-cycle latch then registers.
// - Select seven counts rising edges, select six falling edges.
// - Counter updates 2.5 to 3.5 clocks after a count pin edge.
// - External edges count directly, without prescaling.
// - Prescaler reset bit self-clears; other control bits read zero.
// - Capture pin is ignored while capture value serves as top.
module tfp_timer1_flags
	import tfp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [15:0] counter_value,
	input  wire logic        counter_written,
	input  wire logic        counter_overflow,
	input  wire logic        counter_at_top,
	input  wire logic        counter_at_bottom,
	input  wire logic [3:0]  waveform_mode_select,
	input  wire logic [2:0]  clock_select_t1,
	input  wire logic [2:0]  clock_select_t0,
	input  wire logic        capture_pin,
	input  wire logic        comparator_out,
	input  wire logic        capture_from_comparator,
	input  wire logic        capture_rising,
	input  wire logic        external_count_pin_t1,
	input  wire logic        external_count_pin_t0,
	input  wire logic        global_irq_enable,
	input  wire logic        vector_taken_ovf,
	input  wire logic        vector_taken_match_a,
	input  wire logic        vector_taken_match_b,
	input  wire logic        vector_taken_capture,
	input  wire logic        force_match_a_strobe,
	input  wire logic        force_match_b_strobe,
	output logic             count_pulse_t1,
	output logic             count_pulse_t0,
	output logic             match_a_event,
	output logic             match_b_event,
	output logic             irq_overflow,
	output logic             irq_match_a,
	output logic             irq_match_b,
	output logic             irq_capture,
	output logic [15:0]      compare_a_out,
	output logic [15:0]      compare_b_out,
	output logic [15:0]      capture_out
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0]                 timer_interrupt_mask;
	logic [7:0]                 timer_interrupt_flags;
	logic [7:0]                 high_byte_latch;
	logic [15:0]                compare_a_value;
	logic [15:0]                compare_b_value;
	logic [15:0]                capture_value;
	logic [PRESCALER_WIDTH-1:0] prescaler_count;
	logic                       prescaler_reset_bit;
	logic                       ext_latch_t1;
	logic                       ext_latch_t0;
	logic                       ext_sync_t1;
	logic                       ext_sync_t0;
	logic                       ext_prev_t1;
	logic                       ext_prev_t0;
	logic                       capt_meta;
	logic                       capt_sync;
	logic                       capt_prev;
	logic                       cmp_meta;
	logic                       cmp_sync;
	logic                       hit_a;
	logic                       hit_b;
	logic                       write_block;

	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	wire wr_mask   = reg_wr && (reg_addr == ADDR_MASK);
	wire wr_flags  = reg_wr && (reg_addr == ADDR_FLAGS);
	wire wr_gtc    = reg_wr && (reg_addr == ADDR_GTC);
	wire wr_cmpa   = reg_wr && (reg_addr == ADDR_CMPA_LO);
	wire wr_cmpb   = reg_wr && (reg_addr == ADDR_CMPB_LO);
	wire wr_capt   = reg_wr && (reg_addr == ADDR_CAPT_LO);
	wire wr_high   = reg_wr && ((reg_addr == ADDR_CMPA_HI) || (reg_addr == ADDR_CMPB_HI)
		|| (reg_addr == ADDR_CAPT_HI));
	wire rd_low    = reg_rd && ((reg_addr == ADDR_CMPA_LO) || (reg_addr == ADDR_CMPB_LO)
		|| (reg_addr == ADDR_CAPT_LO));
	wire [15:0] wide_write = {high_byte_latch, reg_wdata};

	logic [15:0] wide_read;
	always_comb begin
		unique case (reg_addr)
			ADDR_CMPA_LO: wide_read = compare_a_value;
			ADDR_CMPB_LO: wide_read = compare_b_value;
			ADDR_CAPT_LO: wide_read = capture_value;
			default:      wide_read = WIDE_RESET;
		endcase
	end

	logic [7:0] next_rdata;
	always_comb begin
		unique case (reg_addr)
			ADDR_MASK:    next_rdata = timer_interrupt_mask;
			ADDR_FLAGS:   next_rdata = timer_interrupt_flags;
			ADDR_GTC:     next_rdata = {7'h00, prescaler_reset_bit};
			ADDR_CMPA_LO,
			ADDR_CMPB_LO,
			ADDR_CAPT_LO: next_rdata = wide_read[7:0];
			ADDR_CMPA_HI,
			ADDR_CMPB_HI,
			ADDR_CAPT_HI: next_rdata = high_byte_latch;
			default:      next_rdata = BYTE_ZERO;
		endcase
	end

	// ---------------------------------------------------------------
	// Shared prescaler and clock selection
	// ---------------------------------------------------------------
	wire tap8    = &prescaler_count[TAP8_BITS-1:0];
	wire tap64   = &prescaler_count[TAP64_BITS-1:0];
	wire tap256  = &prescaler_count[TAP256_BITS-1:0];
	wire tap1024 = &prescaler_count;

	wire ext_rise_t1 = ext_sync_t1 && !ext_prev_t1;
	wire ext_fall_t1 = !ext_sync_t1 && ext_prev_t1;
	wire ext_rise_t0 = ext_sync_t0 && !ext_prev_t0;
	wire ext_fall_t0 = !ext_sync_t0 && ext_prev_t0;

	// Each timer picks its own tap from the one prescaler
	function automatic logic pick_tick(input logic [2:0] sel, input logic rise, input logic fall,
		input logic t8, input logic t64, input logic t256, input logic t1024);
		logic tick;
		tick = 1'b0;
		unique case (sel)
			CS_STOP:     tick = 1'b0;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = t8;
			CS_DIV64:    tick = t64;
			CS_DIV256:   tick = t256;
			CS_DIV1024:  tick = t1024;
			CS_EXT_FALL: tick = fall;
			CS_EXT_RISE: tick = rise;
		endcase
		return tick;
	endfunction : pick_tick

	wire next_pulse_t1 = pick_tick(clock_select_t1, ext_rise_t1, ext_fall_t1,
		tap8, tap64, tap256, tap1024);
	wire next_pulse_t0 = pick_tick(clock_select_t0, ext_rise_t0, ext_fall_t0,
		tap8, tap64, tap256, tap1024);

	// Prescaler keeps running regardless of either selection
	wire [PRESCALER_WIDTH-1:0] next_prescaler = prescaler_reset_bit ? PRESCALER_ZERO
		: prescaler_count + PRESCALER_ONE;

	// ---------------------------------------------------------------
	// Compare, capture and flag sources
	// ---------------------------------------------------------------
	wire capt_is_top = (waveform_mode_select == WM_MATCH_CAPT) || (waveform_mode_select == WM_PFC_CAPT)
		|| (waveform_mode_select == WM_PC_CAPT) || (waveform_mode_select == WM_FAST_CAPT);
	wire capt_src    = capture_from_comparator ? cmp_sync : capt_sync;
	wire capt_edge   = capture_rising ? (capt_src && !capt_prev) : (!capt_src && capt_prev);
	wire capt_event  = capt_edge && !capt_is_top;

	wire mode_at_max = (waveform_mode_select == WM_NORMAL) || (waveform_mode_select == WM_MATCH_A)
		|| (waveform_mode_select == WM_MATCH_CAPT);
	wire mode_at_top = (waveform_mode_select == WM_FAST_8BIT) || (waveform_mode_select == WM_FAST_9BIT)
		|| (waveform_mode_select == WM_FAST_10BIT) || (waveform_mode_select == WM_FAST_CAPT)
		|| (waveform_mode_select == WM_FAST_CMPA);
	wire set_ovf  = mode_at_max ? counter_overflow
		: (mode_at_top ? counter_at_top : counter_at_bottom);

	// Match seen in one timer period raises the flag on the next timer tick
	wire set_cmpa = next_pulse_t1 && hit_a && !write_block;
	wire set_cmpb = next_pulse_t1 && hit_b && !write_block;
	wire set_capt = capt_is_top ? counter_at_top : capt_event;

	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	always_comb begin
		flag_set = BYTE_ZERO;
		flag_clr = wr_flags ? (reg_wdata & T1_FLAG_BITS) : BYTE_ZERO;
		flag_set[BIT_OVF]  = set_ovf;
		flag_set[BIT_CMPA] = set_cmpa;
		flag_set[BIT_CMPB] = set_cmpb;
		flag_set[BIT_CAPT] = set_capt;
		flag_clr[BIT_OVF]  = flag_clr[BIT_OVF] || vector_taken_ovf;
		flag_clr[BIT_CMPA] = flag_clr[BIT_CMPA] || vector_taken_match_a;
		flag_clr[BIT_CMPB] = flag_clr[BIT_CMPB] || vector_taken_match_b;
		flag_clr[BIT_CAPT] = flag_clr[BIT_CAPT] || vector_taken_capture;
	end
	wire [7:0] next_flags = (timer_interrupt_flags & ~flag_clr) | flag_set;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_interrupt_mask  <= MASK_RESET;
			timer_interrupt_flags <= MASK_RESET;
			prescaler_reset_bit   <= 1'b0;
			reg_rdata             <= BYTE_ZERO;
		end else begin
			if (wr_mask) begin
				timer_interrupt_mask <= reg_wdata;
			end
			timer_interrupt_flags <= next_flags;
			prescaler_reset_bit   <= wr_gtc && reg_wdata[BIT_PRESCALER_RESET];
			reg_rdata             <= reg_rd ? next_rdata : BYTE_ZERO;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			high_byte_latch <= BYTE_ZERO;
			compare_a_value <= WIDE_RESET;
			compare_b_value <= WIDE_RESET;
		end else begin
			if (wr_high) begin
				high_byte_latch <= reg_wdata;
			end else if (rd_low) begin
				high_byte_latch <= wide_read[15:8];
			end
			if (wr_cmpa) begin
				compare_a_value <= wide_write;
			end
			if (wr_cmpb) begin
				compare_b_value <= wide_write;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			capture_value <= WIDE_RESET;
		end else if (capt_event) begin
			capture_value <= counter_value;
		end else if (wr_capt) begin
			capture_value <= wide_write;
		end
	end

	// Compare hits are registered each clock; the counter-write block is held until the next timer tick
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hit_a       <= 1'b0;
			hit_b       <= 1'b0;
			write_block <= 1'b0;
		end else begin
			hit_a       <= (counter_value == compare_a_value);
			hit_b       <= (counter_value == compare_b_value);
			write_block <= counter_written || (write_block && !next_pulse_t1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prescaler_count <= PRESCALER_ZERO;
			count_pulse_t1  <= 1'b0;
			count_pulse_t0  <= 1'b0;
		end else begin
			prescaler_count <= next_prescaler;
			count_pulse_t1  <= next_pulse_t1;
			count_pulse_t0  <= next_pulse_t0;
		end
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Falling-edge capture stands in for a latch open in the high phase
	always_ff @(negedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_latch_t1 <= 1'b0;
			ext_latch_t0 <= 1'b0;
		end else begin
			ext_latch_t1 <= external_count_pin_t1;
			ext_latch_t0 <= external_count_pin_t0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_sync_t1 <= 1'b0;
			ext_sync_t0 <= 1'b0;
			ext_prev_t1 <= 1'b0;
			ext_prev_t0 <= 1'b0;
		end else begin
			ext_sync_t1 <= ext_latch_t1;
			ext_sync_t0 <= ext_latch_t0;
			ext_prev_t1 <= ext_sync_t1;
			ext_prev_t0 <= ext_sync_t0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			capt_meta <= 1'b0;
			capt_sync <= 1'b0;
			capt_prev <= 1'b0;
			cmp_meta  <= 1'b0;
			cmp_sync  <= 1'b0;
		end else begin
			capt_meta <= capture_pin;
			capt_sync <= capt_meta;
			cmp_meta  <= comparator_out;
			cmp_sync  <= cmp_meta;
			capt_prev <= capt_src;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			match_a_event <= 1'b0;
			match_b_event <= 1'b0;
			irq_overflow  <= 1'b0;
			irq_match_a   <= 1'b0;
			irq_match_b   <= 1'b0;
			irq_capture   <= 1'b0;
			compare_a_out <= WIDE_RESET;
			compare_b_out <= WIDE_RESET;
			capture_out   <= WIDE_RESET;
		end else begin
			match_a_event <= set_cmpa || force_match_a_strobe;
			match_b_event <= set_cmpb || force_match_b_strobe;
			irq_overflow  <= global_irq_enable && timer_interrupt_mask[BIT_OVF]
				&& timer_interrupt_flags[BIT_OVF];
			irq_match_a   <= global_irq_enable && timer_interrupt_mask[BIT_CMPA]
				&& timer_interrupt_flags[BIT_CMPA];
			irq_match_b   <= global_irq_enable && timer_interrupt_mask[BIT_CMPB]
				&& timer_interrupt_flags[BIT_CMPB];
			irq_capture   <= global_irq_enable && timer_interrupt_mask[BIT_CAPT]
				&& timer_interrupt_flags[BIT_CAPT];
			compare_a_out <= compare_a_value;
			compare_b_out <= compare_b_value;
			capture_out   <= capture_value;
		end
	end

endmodule : tfp_timer1_flags

// ---- tfp_timer1_flags_props.sv ----
`timescale 1ns/1ps
module tfp_timer1_flags_props
	import tfp_pkg::*;
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [2:0]  clock_select_t1,
	input wire logic [2:0]  clock_select_t0,
	input wire logic        external_count_pin_t1,
	input wire logic        external_count_pin_t0,
	input wire logic        global_irq_enable,
	input wire logic        count_pulse_t1,
	input wire logic        count_pulse_t0,
	input wire logic        irq_overflow,
	input wire logic        irq_match_a,
	input wire logic        irq_match_b,
	input wire logic        irq_capture,
	input wire logic [15:0] compare_a_out,
	input wire logic [15:0] compare_b_out
);
	// ---------------------------------------------------------------
	// Settling after reset, so history from reset time is not judged
	// ---------------------------------------------------------------
	logic [1:0] up_cnt;
	wire        up = (up_cnt == 2'h3);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			up_cnt <= 2'h0;
		else if (!up)
			up_cnt <= up_cnt + 2'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	rd_idle_a: assert property (up && !$past(reg_rd) |-> reg_rdata == BYTE_ZERO) else $error("read data not idle");
	gtc_reserved_a: assert property (up && $past(reg_rd) && $past(reg_addr) == ADDR_GTC |-> reg_rdata[7:1] == 7'h00)
		else $error("reserved control bits not zero");
	irq_gate_a: assert property (up && (irq_overflow || irq_match_a || irq_match_b || irq_capture)
		|-> $past(global_irq_enable)) else $error("irq without global enable");
	div1_tick_a: assert property (up && $past(clock_select_t1) == CS_DIV1 |-> count_pulse_t1)
		else $error("select one did not tick");
	stop_quiet_a: assert property (up && $past(clock_select_t0) == CS_STOP |-> !count_pulse_t0)
		else $error("stopped timer ticked");
	ext_rise_a: assert property (up && $rose(external_count_pin_t1) && clock_select_t1 == CS_EXT_RISE
		|-> ##[1:4] count_pulse_t1) else $error("rising pin edge not counted");
	ext_fall_a: assert property (up && $fell(external_count_pin_t0) && clock_select_t0 == CS_EXT_FALL
		|-> ##[1:4] count_pulse_t0) else $error("falling pin edge not counted");
	cmpa_write_a: assert property (up && $changed(compare_a_out) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == ADDR_CMPA_LO)
		else $error("compare A changed without low write");
	cmpb_write_a: assert property (up && $changed(compare_b_out) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == ADDR_CMPB_LO)
		else $error("compare B changed without low write");
endmodule : tfp_timer1_flags_props

bind tfp_timer1_flags tfp_timer1_flags_props i_tfp_timer1_flags_props (.clk(clk), .arst_n(arst_n),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.clock_select_t1(clock_select_t1), .clock_select_t0(clock_select_t0),
	.external_count_pin_t1(external_count_pin_t1), .external_count_pin_t0(external_count_pin_t0),
	.global_irq_enable(global_irq_enable), .count_pulse_t1(count_pulse_t1), .count_pulse_t0(count_pulse_t0),
	.irq_overflow(irq_overflow), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
	.irq_capture(irq_capture), .compare_a_out(compare_a_out), .compare_b_out(compare_b_out));

// ---- tfp_timer1_flags_tb.sv ----
`timescale 1ns/1ps
module tfp_timer1_flags_tb;
	import tfp_pkg::*;
	logic        clk, arst_n, reg_wr, reg_rd, counter_written, comparator_out, capture_from_comparator;
	logic        capture_rising, global_irq_enable, capture_pin, ext_pin;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
	logic [15:0] counter_value, w, cnt1, cnt0, ev_a, ev_b, n1, n0;
	logic [3:0]  waveform_mode_select;
	logic [2:0]  cs1, cs0;
	logic [8:0]  strb;
	logic        count_pulse_t1, count_pulse_t0, match_a_event, match_b_event;
	logic        irq_overflow, irq_match_a, irq_match_b, irq_capture;
	logic [15:0] compare_a_out, compare_b_out, capture_out;
	logic [3:0]  modes [3] = '{WM_NORMAL, WM_FAST_8BIT, WM_PFC_CAPT};
	int          error_cnt = 0;
	int          check_count = 0;
	int          f1, f0;

	tfp_timer1_flags i_tfp_timer1_flags (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .counter_value(counter_value),
		.counter_written(counter_written), .counter_overflow(strb[0]), .counter_at_top(strb[1]),
		.counter_at_bottom(strb[2]), .waveform_mode_select(waveform_mode_select), .clock_select_t1(cs1),
		.clock_select_t0(cs0), .capture_pin(capture_pin), .comparator_out(comparator_out),
		.capture_from_comparator(capture_from_comparator), .capture_rising(capture_rising),
		.external_count_pin_t1(ext_pin), .external_count_pin_t0(ext_pin), .global_irq_enable(global_irq_enable),
		.vector_taken_ovf(strb[3]), .vector_taken_match_a(strb[4]), .vector_taken_match_b(strb[5]),
		.vector_taken_capture(strb[6]), .force_match_a_strobe(strb[7]), .force_match_b_strobe(strb[8]),
		.count_pulse_t1(count_pulse_t1), .count_pulse_t0(count_pulse_t0), .match_a_event(match_a_event),
		.match_b_event(match_b_event), .irq_overflow(irq_overflow), .irq_match_a(irq_match_a),
		.irq_match_b(irq_match_b), .irq_capture(irq_capture), .compare_a_out(compare_a_out),
		.compare_b_out(compare_b_out), .capture_out(capture_out));
	tfp_pin_model i_tfp_pin_model (.clk(clk), .capture_pin(capture_pin), .count_pin(ext_pin));

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cnt1 <= cnt1 + {15'h0000, count_pulse_t1};
		cnt0 <= cnt0 + {15'h0000, count_pulse_t0};
		ev_a <= ev_a + {15'h0000, match_a_event};
		ev_b <= ev_b + {15'h0000, match_b_event};
	end
	// ---------------------------------------------------------------
	// Bus tasks and comparison
	// ---------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
		@(posedge clk);
	endtask : rd
	task automatic wr16(input logic [7:0] hi, input logic [15:0] val);
		wr(hi, val[15:8]);
		wr(hi - 8'h01, val[7:0]);
	endtask : wr16
	task automatic rd16(input logic [7:0] lo, output logic [15:0] val);
		rd(lo, val[7:0]);
		rd(lo + 8'h01, val[15:8]);
	endtask : rd16
	task automatic pulse(input int i);
		strb[i] <= 1'h1;
		@(posedge clk);
		strb[i] <= 1'h0;
		@(posedge clk);
	endtask : pulse
	task automatic flags(input logic [7:0] exp);
		rd(ADDR_FLAGS, v);
		chk({8'h00, v & T1_FLAG_BITS}, {8'h00, exp});
	endtask : flags
	function automatic int divof(input int c);
		return (c == 1) ? 1 : (c == 2) ? 8 : (c == 3) ? 64 : (c == 4) ? 256 : 1024;
	endfunction : divof
	task automatic conclude();
		if (error_cnt == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		conclude();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, strb, counter_value, counter_written, comparator_out} = '0;
		{capture_from_comparator, capture_rising, global_irq_enable, waveform_mode_select, cs1, cs0} = '0;
		{cnt1, cnt0, ev_a, ev_b} = '0;
		arst_n = 1'h0;
		repeat (16) @(posedge clk);
		arst_n <= 1'h1;
		@(posedge clk);
		rd(ADDR_MASK, v);
		chk({8'h00, v}, {8'h00, MASK_RESET});
		wr(ADDR_MASK, 8'hFF);
		rd(ADDR_MASK, v);
		chk({8'h00, v}, 16'h00FF);
		wr(8'h10, 8'hAA);
		rd(8'h10, v);
		chk({8'h00, v}, 16'h0000);
		wr16(ADDR_CMPA_HI, 16'h1234);
		@(posedge clk);
		chk(compare_a_out, 16'h1234);
		wr16(ADDR_CMPB_HI, 16'h8055);
		rd16(ADDR_CMPA_LO, w);
		chk(w, 16'h1234);
		rd16(ADDR_CMPB_LO, w);
		chk(w, 16'h8055);
		wr(ADDR_MASK, 8'h60);
		global_irq_enable <= 1'h1;
		cs1 <= CS_DIV1;
		counter_value <= 16'h1234;
		repeat (4) @(posedge clk);
		chk({15'h0000, irq_match_a}, 16'h0001);
		flags(8'h40);
		wr(ADDR_FLAGS, 8'h40);
		flags(8'h40);
		counter_value <= 16'h8055;
		repeat (4) @(posedge clk);
		cs1 <= CS_STOP;
		counter_value <= 16'h0000;
		wr(ADDR_FLAGS, 8'h00);
		flags(8'h60);
		wr(ADDR_FLAGS, 8'h40);
		flags(8'h20);
		global_irq_enable <= 1'h0;
		repeat (2) @(posedge clk);
		chk({15'h0000, irq_match_b}, 16'h0000);
		pulse(5);
		flags(8'h00);
		n1 = ev_a;
		pulse(7);
		@(posedge clk);
		chk(ev_a - n1, 16'h0001);
		n1 = ev_b;
		pulse(8);
		@(posedge clk);
		chk(ev_b - n1, 16'h0001);
		flags(8'h00);
		for (int i = 0; i < 3; i++) begin
			waveform_mode_select <= modes[i];
			@(posedge clk);
			pulse(i);
			flags(8'h80);
			pulse(3);
			flags(8'h00);
		end
		waveform_mode_select <= WM_NORMAL;
		capture_rising <= 1'h1;
		counter_value <= 16'hABCD;
		wr(ADDR_MASK, 8'h08);
		global_irq_enable <= 1'h1;
		i_tfp_pin_model.set_capture(1'h1);
		repeat (6) @(posedge clk);
		chk(capture_out, 16'hABCD);
		chk({15'h0000, irq_capture}, 16'h0001);
		rd16(ADDR_CAPT_LO, w);
		chk(w, 16'hABCD);
		pulse(6);
		flags(8'h00);
		waveform_mode_select <= WM_MATCH_CAPT;
		capture_rising <= 1'h0;
		counter_value <= 16'h0F0F;
		i_tfp_pin_model.set_capture(1'h0);
		repeat (6) @(posedge clk);
		chk(capture_out, 16'hABCD);
		pulse(1);
		flags(8'h08);
		waveform_mode_select <= WM_NORMAL;
		cs1 <= CS_EXT_RISE;
		cs0 <= CS_EXT_FALL;
		n1 = cnt1;
		n0 = cnt0;
		repeat (2) @(posedge clk);
		i_tfp_pin_model.run_clock(10, 3);
		repeat (6) @(posedge clk);
		chk(cnt1 - n1, 16'h000A);
		chk(cnt0 - n0, 16'h000A);
		for (int c = 1; c < 6; c++) begin
			cs1 <= 3'(c);
			cs0 <= 3'((c == 5) ? 2 : c + 1);
			repeat (2) @(posedge clk);
			n1 = cnt1;
			n0 = cnt0;
			repeat (2048) @(posedge clk);
			chk(cnt1 - n1, 16'(2048 / divof(c)));
			chk(cnt0 - n0, 16'(2048 / divof((c == 5) ? 2 : c + 1)));
		end
		cs1 <= CS_DIV8;
		cs0 <= CS_DIV64;
		repeat (100) @(posedge clk);
		wr(ADDR_GTC, 8'h01);
		repeat (2) @(posedge clk);
		n1 = cnt1;
		n0 = cnt0;
		f1 = 0;
		f0 = 0;
		for (int k = 1; k < 80; k++) begin
			@(posedge clk);
			if (f1 == 0 && cnt1 != n1)
				f1 = k;
			if (f0 == 0 && cnt0 != n0)
				f0 = k;
		end
		chk(16'(f1 >= 8 && f1 <= 12), 16'h0001);
		chk(16'(f0 >= 64 && f0 <= 68), 16'h0001);
		rd(ADDR_GTC, v);
		chk({8'h00, v}, 16'h0000);
		wr(ADDR_GTC, 8'hFE);
		rd(ADDR_GTC, v);
		chk({8'h00, v}, 16'h0000);
		conclude();
	end
endmodule : tfp_timer1_flags_tb
